// ===== can_mb_cfg.svh
`ifndef CAN_MB_CFG_SVH
`define CAN_MB_CFG_SVH

// Register offsets inside one message buffer
`define MB_OFS_ID_HIGH    4'h0
`define MB_OFS_ID_LOW     4'h1
`define MB_OFS_ID_THIRD   4'h2
`define MB_OFS_ID_FOURTH  4'h3
`define MB_OFS_PAYLOAD0   4'h4
`define MB_OFS_PAYLOAD7   4'hB
`define MB_OFS_LENGTH     4'hC

// Field positions in the second identifier register and the length register
`define MB_IDLO_MSB       7
`define MB_IDLO_LSB       5
`define MB_BIT_RTR        4
`define MB_BIT_IDE        3
`define MB_DLC_MSB        3

// Widths and counts
`define MB_ADDR_W         4
`define MB_ID_W           11
`define MB_NBYTES         8
`define MB_MAX_COUNT      4'h8
`define MB_ID_LAST        4'hA
`define MB_DLC_LAST       4'h3
`define MB_BIT_LAST       4'h7
`define MB_ZERO8          8'h00
`define MB_ZERO4          4'h0
`define MB_ONE4           4'h1

`endif

// ===== can_mb_pkg.sv
`include "can_mb_cfg.svh"

package can_mb_pkg;

	// One byte of buffer storage
	typedef logic [7:0] byte_t;

	// Serializer progress through the frame fields
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ID   = 7'h02,
		ST_RTR  = 7'h04,
		ST_IDE  = 7'h08,
		ST_DLC  = 7'h10,
		ST_DATA = 7'h20,
		ST_DONE = 7'h40
	} tx_state_t;

endpackage : can_mb_pkg

// ===== can_mb_dlc.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_mb_cfg.svh"

// Turns a length code into the number of payload bytes on the wire
module can_mb_dlc
	import can_mb_pkg::*;
(
	input  wire logic [3:0] dlc_i,
	input  wire logic       remote_i,
	output logic      [3:0] count_o
);

	// Remote frames carry no bytes; codes above eight are clamped
	always_comb begin
		if (remote_i) begin
			count_o = `MB_ZERO4;
		end else if (dlc_i > `MB_MAX_COUNT) begin
			count_o = `MB_MAX_COUNT;
		end else begin
			count_o = dlc_i;
		end
	end

endmodule : can_mb_dlc

`default_nettype wire

// ===== can_mb_bitsel.sv
`timescale 1ns/1ps
`default_nettype none

// Picks bit number idx counted from the most significant end
module can_mb_bitsel #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] vec_i,
	input  wire logic [3:0]   idx_i,
	output logic              bit_o
);

	// Out-of-range index gives a dominant zero rather than an X
	always_comb begin
		if (int'(idx_i) < W) begin
			bit_o = vec_i[W-1-int'(idx_i)];
		end else begin
			bit_o = 1'b0;
		end
	end

endmodule : can_mb_bitsel

`default_nettype wire

// ===== can_mb_std.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_mb_cfg.svh"

module can_mb_std
	import can_mb_pkg::*;
(
	input  wire logic                  MCLK,
	input  wire logic                  SYS_RST,
	input  wire logic [`MB_ADDR_W-1:0] ADDR,
	input  wire logic [7:0]            WDATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic      [7:0]            RDATA,
	input  wire logic                  TX_START,
	input  wire logic                  TX_BIT_STB,
	input  wire logic                  BUS_BIT,
	output logic                       TX_BIT,
	output logic                       TX_BUSY,
	output logic                       TX_DONE,
	output logic                       ARB_LOST,
	output logic                       TX_REFUSED,
	input  wire logic                  RX_FRAME_WE,
	input  wire logic [`MB_ID_W-1:0]   RX_ID,
	input  wire logic                  RX_RTR,
	input  wire logic                  RX_IDE,
	input  wire logic [3:0]            RX_DLC,
	input  wire logic                  RX_BYTE_WE,
	input  wire logic [2:0]            RX_BYTE_IDX,
	input  wire logic [7:0]            RX_BYTE,
	output logic                       RTR_FLAG,
	output logic                       FMT_EXT
);

	byte_t            std_id_high_q;       // Identifier upper eight bits
	byte_t            std_id_low_flags_q;  // Identifier low bits and flags
	byte_t            id_third_q;          // Kept for extended use only
	byte_t            id_fourth_q;         // Kept for extended use only
	byte_t            payload_bytes_q [`MB_NBYTES];  // Payload storage
	logic       [3:0] payload_length_q;    // Length code
	tx_state_t        state_q;             // Serializer state
	logic       [3:0] cnt_q;               // Bit index within a field
	logic       [2:0] byte_q;              // Byte index within payload
	logic       [3:0] tx_count_q;          // Bytes to send, frozen at start
	logic       [3:0] cur_count;           // Bytes to send or to accept
	logic [`MB_ID_W-1:0] std_id;           // Joined eleven-bit identifier
	logic       [3:0] id_idx;              // Next identifier bit index
	logic             id_bit;              // Next identifier bit
	logic       [2:0] dat_byte;            // Next payload byte index
	logic       [3:0] dat_idx;             // Next payload bit index
	logic             dat_bit;             // Next payload bit
	logic             sw_wr_ok;            // Software write not shadowed
	logic             start_ok;            // Start accepted this cycle
	logic             lost;                // Recessive sent, dominant seen

	// Identifier joins high register and top three bits of the low one
	assign std_id = {std_id_high_q,
		std_id_low_flags_q[`MB_IDLO_MSB:`MB_IDLO_LSB]};

	// Reception takes the buffer over; a clashing software write is lost
	assign sw_wr_ok = WR && !RX_FRAME_WE;

	// Extended format is not serialized here, so such a start is refused
	assign start_ok = TX_START && (state_q == ST_IDLE) &&
		!std_id_low_flags_q[`MB_BIT_IDE];

	// Only identifier and remote bit take part in arbitration
	assign lost = TX_BIT_STB && TX_BIT && !BUS_BIT &&
		((state_q == ST_ID) || (state_q == ST_RTR));

	// One decoder serves both sending and capture: same count rule
	can_mb_dlc u_tx_dlc (
		.dlc_i    (payload_length_q),
		.remote_i (std_id_low_flags_q[`MB_BIT_RTR]),
		.count_o  (cur_count)
	);

	// Next identifier bit, walking from the top down
	assign id_idx = (state_q == ST_ID) ? cnt_q + `MB_ONE4 : `MB_ZERO4;

	can_mb_bitsel #(
		.W (`MB_ID_W)
	) u_id_sel (
		.vec_i (std_id),
		.idx_i (id_idx),
		.bit_o (id_bit)
	);

	// Next payload bit; rolls to the following byte after bit seven
	always_comb begin
		dat_byte = 3'h0;
		dat_idx  = `MB_ZERO4;
		if ((state_q == ST_DATA) && (cnt_q != `MB_BIT_LAST)) begin
			dat_byte = byte_q;
			dat_idx  = cnt_q + `MB_ONE4;
		end else if (state_q == ST_DATA) begin
			dat_byte = byte_q + 3'h1;
		end
	end

	can_mb_bitsel #(
		.W (8)
	) u_dat_sel (
		.vec_i (payload_bytes_q[dat_byte]),
		.idx_i (dat_idx),
		.bit_o (dat_bit)
	);

	// First identifier register
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			std_id_high_q <= `MB_ZERO8;
		end else if (RX_FRAME_WE) begin
			std_id_high_q <= RX_ID[`MB_ID_W-1:3];
		end else if (sw_wr_ok && (ADDR == `MB_OFS_ID_HIGH)) begin
			std_id_high_q <= WDATA;
		end
	end

	// Second identifier register; reception leaves bits 2-0 alone
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			std_id_low_flags_q <= `MB_ZERO8;
		end else if (RX_FRAME_WE) begin
			std_id_low_flags_q[`MB_IDLO_MSB:`MB_IDLO_LSB] <= RX_ID[2:0];
			std_id_low_flags_q[`MB_BIT_RTR] <= RX_RTR;
			std_id_low_flags_q[`MB_BIT_IDE] <= RX_IDE;
		end else if (sw_wr_ok && (ADDR == `MB_OFS_ID_LOW)) begin
			std_id_low_flags_q <= WDATA;
		end
	end

	// Third and fourth identifier registers: stored, never sent here
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			id_third_q  <= `MB_ZERO8;
			id_fourth_q <= `MB_ZERO8;
		end else begin
			if (sw_wr_ok && (ADDR == `MB_OFS_ID_THIRD)) begin
				id_third_q <= WDATA;
			end
			if (sw_wr_ok && (ADDR == `MB_OFS_ID_FOURTH)) begin
				id_fourth_q <= WDATA;
			end
		end
	end

	// Length register holds the code in its low nibble
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			payload_length_q <= `MB_ZERO4;
		end else if (RX_FRAME_WE) begin
			payload_length_q <= RX_DLC;
		end else if (sw_wr_ok && (ADDR == `MB_OFS_LENGTH)) begin
			payload_length_q <= WDATA[`MB_DLC_MSB:0];
		end
	end

	// Payload bytes; reception beyond the length code is dropped
	for (genvar i = 0; i < `MB_NBYTES; i++) begin : g_payload
		always_ff @(posedge MCLK or posedge SYS_RST) begin
			if (SYS_RST) begin
				payload_bytes_q[i] <= `MB_ZERO8;
			end else if (RX_BYTE_WE && (int'(RX_BYTE_IDX) == i)) begin
				if ({1'b0, RX_BYTE_IDX} < cur_count) begin
					payload_bytes_q[i] <= RX_BYTE;
				end
			end else if (sw_wr_ok && (ADDR == `MB_OFS_PAYLOAD0 + 4'(i))) begin
				payload_bytes_q[i] <= WDATA;
			end
		end
	end

	// Read data stand one cycle after the strobe and only then
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDATA <= `MB_ZERO8;
		end else if (!RD) begin
			RDATA <= `MB_ZERO8;
		end else if ((ADDR >= `MB_OFS_PAYLOAD0) &&
				(ADDR <= `MB_OFS_PAYLOAD7)) begin
			RDATA <= payload_bytes_q[3'(ADDR - `MB_OFS_PAYLOAD0)];
		end else begin
			unique case (ADDR)
				`MB_OFS_ID_HIGH:   RDATA <= std_id_high_q;
				`MB_OFS_ID_LOW:    RDATA <= std_id_low_flags_q;
				// Unused in standard mapping; value carries no meaning
				`MB_OFS_ID_THIRD:  RDATA <= id_third_q;
				`MB_OFS_ID_FOURTH: RDATA <= id_fourth_q;
				`MB_OFS_LENGTH:    RDATA <= {4'h0, payload_length_q};
				default:           RDATA <= `MB_ZERO8;
			endcase
		end
	end

	// Frame serializer: one field step per bit strobe
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_q    <= ST_IDLE;
			cnt_q      <= `MB_ZERO4;
			byte_q     <= 3'h0;
			tx_count_q <= `MB_ZERO4;
			TX_BIT     <= 1'b1;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_ok) begin
						state_q    <= ST_ID;
						cnt_q      <= `MB_ZERO4;
						byte_q     <= 3'h0;
						tx_count_q <= cur_count;
						TX_BIT     <= std_id[`MB_ID_W-1];
					end
				end
				ST_ID: begin
					if (lost) begin
						state_q <= ST_IDLE;
						TX_BIT  <= 1'b1;
					end else if (TX_BIT_STB && (cnt_q == `MB_ID_LAST)) begin
						state_q <= ST_RTR;
						TX_BIT  <= std_id_low_flags_q[`MB_BIT_RTR];
					end else if (TX_BIT_STB) begin
						cnt_q  <= cnt_q + `MB_ONE4;
						TX_BIT <= id_bit;
					end
				end
				ST_RTR: begin
					if (lost) begin
						state_q <= ST_IDLE;
						TX_BIT  <= 1'b1;
					end else if (TX_BIT_STB) begin
						// Only standard starts get here, so the flag is zero
						state_q <= ST_IDE;
						TX_BIT  <= std_id_low_flags_q[`MB_BIT_IDE];
					end
				end
				ST_IDE: begin
					if (TX_BIT_STB) begin
						state_q <= ST_DLC;
						cnt_q   <= `MB_ZERO4;
						TX_BIT  <= payload_length_q[`MB_DLC_MSB];
					end
				end
				ST_DLC: begin
					if (TX_BIT_STB && (cnt_q == `MB_DLC_LAST)) begin
						cnt_q  <= `MB_ZERO4;
						TX_BIT <= payload_bytes_q[0][7];
						if (tx_count_q == `MB_ZERO4) begin
							state_q <= ST_DONE;
						end else begin
							state_q <= ST_DATA;
						end
					end else if (TX_BIT_STB) begin
						cnt_q  <= cnt_q + `MB_ONE4;
						TX_BIT <= payload_length_q[2'(`MB_DLC_LAST - cnt_q
							- `MB_ONE4)];
					end
				end
				ST_DATA: begin
					if (TX_BIT_STB && (cnt_q == `MB_BIT_LAST) &&
							({1'b0, byte_q} == tx_count_q - `MB_ONE4)) begin
						state_q <= ST_DONE;
						TX_BIT  <= 1'b1;
					end else if (TX_BIT_STB) begin
						cnt_q  <= dat_idx;
						byte_q <= dat_byte;
						TX_BIT <= dat_bit;
					end
				end
				ST_DONE: begin
					state_q <= ST_IDLE;
					TX_BIT  <= 1'b1;
				end
			endcase
		end
	end

	// Status pulses and busy level
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			TX_BUSY    <= 1'b0;
			TX_DONE    <= 1'b0;
			ARB_LOST   <= 1'b0;
			TX_REFUSED <= 1'b0;
		end else begin
			TX_BUSY    <= start_ok || ((state_q != ST_IDLE) &&
				(state_q != ST_DONE) && !lost);
			TX_DONE    <= (state_q == ST_DONE);
			ARB_LOST   <= lost;
			TX_REFUSED <= TX_START && (state_q == ST_IDLE) && !start_ok;
		end
	end

	// Flag outputs mirror the stored flags
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RTR_FLAG <= 1'b0;
			FMT_EXT  <= 1'b0;
		end else begin
			RTR_FLAG <= std_id_low_flags_q[`MB_BIT_RTR];
			FMT_EXT  <= std_id_low_flags_q[`MB_BIT_IDE];
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	a_rx_id_split: assert property (RX_FRAME_WE |=>
		std_id_high_q == $past(RX_ID[10:3]) &&
		std_id_low_flags_q[7:5] == $past(RX_ID[2:0]))
		else $error("received identifier stored wrongly");
	a_first_bit_msb: assert property (start_ok |=>
		TX_BIT == $past(std_id_high_q[7]) && state_q == ST_ID)
		else $error("first sent bit is not identifier top bit");
	a_arb_lost_stop: assert property (lost |=>
		ARB_LOST && state_q == ST_IDLE ##1 !TX_BUSY)
		else $error("lost arbitration did not stop sending");
	a_rtr_bit_sent: assert property (state_q == ST_RTR &&
		$past(state_q) == ST_ID |->
		TX_BIT == $past(std_id_low_flags_q[`MB_BIT_RTR]))
		else $error("sent remote bit differs from flag");
	a_rx_flags: assert property (RX_FRAME_WE |=>
		std_id_low_flags_q[4] == $past(RX_RTR) ##1 RTR_FLAG == $past(RX_RTR, 2))
		else $error("received remote flag not stored");
	a_ext_refused: assert property (TX_START && state_q == ST_IDLE &&
		std_id_low_flags_q[3] |=> TX_REFUSED && state_q == ST_IDLE)
		else $error("extended start not refused");
	a_rx_format: assert property (RX_FRAME_WE |=>
		std_id_low_flags_q[3] == $past(RX_IDE))
		else $error("received format flag not stored");
	a_payload_write: assert property (sw_wr_ok && !RX_BYTE_WE &&
		ADDR == `MB_OFS_PAYLOAD0 |=> payload_bytes_q[0] == $past(WDATA))
		else $error("payload byte write lost");
	a_rx_beyond_len: assert property (RX_BYTE_WE &&
		{1'b0, RX_BYTE_IDX} >= cur_count |=>
		payload_bytes_q[$past(RX_BYTE_IDX)] ==
		$past(payload_bytes_q[RX_BYTE_IDX]))
		else $error("byte beyond length code captured");
	a_count_limit: assert property (tx_count_q <= 4'h8)
		else $error("byte count above eight");
	a_remote_nodata: assert property (state_q == ST_DATA |->
		tx_count_q != 4'h0 && {1'b0, byte_q} < tx_count_q)
		else $error("payload sent beyond count or for remote");
	a_done_pulse: assert property (state_q == ST_DONE |=>
		TX_DONE && state_q == ST_IDLE)
		else $error("frame end not reported");

	c_tx_done:  cover property (TX_DONE);
	c_arb_lost: cover property (ARB_LOST);
	c_rx_frame: cover property (RX_FRAME_WE ##[1:8] RX_BYTE_WE);
	c_remote:   cover property (start_ok && std_id_low_flags_q[4]);

endmodule : can_mb_std

`default_nettype wire

// ===== can_bus_node.sv
`timescale 1ns/1ps
`default_nettype none

// Other nodes on the bus: strobe each bit the buffer offers and return
// the wired-AND bus level; an optional rival node arbitrates against it
module can_bus_node (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        tx_bit,   // Bit offered by the buffer
	input  wire logic        tx_busy,  // Frame in progress
	input  wire logic        slow,     // Four-cycle bit time
	input  wire logic        rival_en, // Rival node arbitrates
	input  wire logic [11:0] rival,    // Rival identifier and remote bit
	output logic             stb,      // Bit strobe to the buffer
	output logic             bus_bit,  // Resolved bus level
	output logic [127:0]     cap,      // Bus levels seen, first at 0
	output int               ncap      // Number of bits seen
);
	logic [1:0] gap_q;  // Cycles since the last strobe
	logic       busy_q; // Busy one cycle ago, to spot a new frame
	logic       out_q;  // Rival has dropped out of arbitration

	// Dominant zero wins; an idle bus rests recessive
	always_comb begin
		bus_bit = tx_busy ? tx_bit : 1'b1;
		if (rival_en && !out_q && ncap < 12) begin
			bus_bit = bus_bit & rival[11 - ncap];
		end
	end

	// Never two strobes in a row, so the next bit has settled first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stb <= 1'b0;
			gap_q <= 2'd0;
			busy_q <= 1'b0;
			out_q <= 1'b0;
			ncap <= 0;
			cap <= '0;
		end else begin
			busy_q <= tx_busy;
			stb <= 1'b0;
			if (tx_busy && !busy_q) begin
				// New frame: forget the last one
				ncap <= 0;
				gap_q <= 2'd0;
				out_q <= 1'b0;
			end else if (tx_busy && !stb) begin
				if (gap_q == (slow ? 2'd2 : 2'd0)) begin
					stb <= 1'b1;
					gap_q <= 2'd0;
				end else begin
					gap_q <= gap_q + 2'd1;
				end
			end
			// A strobe raised as the frame ends meets an idle buffer:
			// it carries no bit and must not be counted
			if (stb && tx_busy) begin
				cap[ncap] <= bus_bit;
				ncap <= ncap + 1;
				// Rival sent recessive but saw dominant: it backs off
				if (rival_en && ncap < 12 && rival[11 - ncap] && !bus_bit) begin
					out_q <= 1'b1;
				end
			end
		end
	end
endmodule : can_bus_node

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import can_mb_pkg::*;

	logic         MCLK = 1'b0;
	logic         SYS_RST = 1'b1;
	logic [3:0]   ADDR, RX_DLC;
	byte_t        WDATA, RDATA, RX_BYTE;
	logic         WR, RD, TX_START, TX_BIT_STB, BUS_BIT, TX_BIT, TX_BUSY;
	logic         TX_DONE, ARB_LOST, TX_REFUSED, RX_FRAME_WE, RX_RTR;
	logic         RX_IDE, RX_BYTE_WE, RTR_FLAG, FMT_EXT, slow, rival_en;
	logic [10:0]  RX_ID;
	logic [2:0]   RX_BYTE_IDX;
	logic [11:0]  rival;
	logic [127:0] cap;
	int           ncap;
	int           num_errors = 0;
	int           samples_checked = 0;

	// 250 MHz system clock
	always #2 MCLK = ~MCLK;

	can_mb_std can_mb_std_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_START(TX_START),
		.TX_BIT_STB(TX_BIT_STB), .BUS_BIT(BUS_BIT), .TX_BIT(TX_BIT),
		.TX_BUSY(TX_BUSY), .TX_DONE(TX_DONE), .ARB_LOST(ARB_LOST),
		.TX_REFUSED(TX_REFUSED), .RX_FRAME_WE(RX_FRAME_WE), .RX_ID(RX_ID),
		.RX_RTR(RX_RTR), .RX_IDE(RX_IDE), .RX_DLC(RX_DLC),
		.RX_BYTE_WE(RX_BYTE_WE), .RX_BYTE_IDX(RX_BYTE_IDX), .RX_BYTE(RX_BYTE),
		.RTR_FLAG(RTR_FLAG), .FMT_EXT(FMT_EXT));

	can_bus_node can_bus_node_i (.clk(MCLK), .rst(SYS_RST), .tx_bit(TX_BIT),
		.tx_busy(TX_BUSY), .slow(slow), .rival_en(rival_en), .rival(rival),
		.stb(TX_BIT_STB), .bus_bit(BUS_BIT), .cap(cap), .ncap(ncap));

	// Register test pattern, distinct for every offset
	function automatic byte_t pat(input int a);
		return 8'(8'hC5 + 8'h17 * a);
	endfunction : pat

	task automatic chk(input string what, input logic [127:0] exp,
			input logic [127:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : chk

	// One idle cycle after each strobe keeps drivers single per time step
	task automatic wr(input logic [3:0] a, input byte_t d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
		@(posedge MCLK);
	endtask : wr

	task automatic rd(input logic [3:0] a, output byte_t d);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge MCLK);
		RD <= 1'b0;
		#1 d = RDATA;
		@(posedge MCLK);
	endtask : rd

	// Fill a buffer; unused identifier bits get junk that must not leak
	task automatic load(input logic [10:0] id, input logic rtr,
			input logic ide, input logic [3:0] dlc);
		wr(4'h0, id[10:3]);
		wr(4'h1, {id[2:0], rtr, ide, 3'b101});
		wr(4'h2, 8'h5A);
		wr(4'h3, 8'hA5);
		for (int i = 4; i < 12; i++) wr(4'(i), pat(i));
		wr(4'hC, {4'hF, dlc});
	endtask : load

	// Send one frame and judge the bits seen on the bus
	task automatic send(input logic [10:0] id, input logic rtr,
			input logic [3:0] dlc, input logic sl, input logic re,
			input logic [11:0] rv, input logic lose);
		logic [127:0] e;
		logic [16:0]  hdr;
		byte_t        b;
		int           nb;
		int           n;
		logic         done;
		logic         lost;
		e = '0;
		done = 1'b0;
		lost = 1'b0;
		hdr = {id, rtr, 1'b0, dlc};
		nb = rtr ? 0 : (dlc > 4'h8 ? 8 : int'(dlc));
		n = 17 + 8 * nb;
		for (int k = 0; k < 17; k++) e[k] = hdr[16 - k];
		for (int k = 0; k < 8 * nb; k++) begin
			b = pat(4 + k / 8);
			e[17 + k] = b[7 - k % 8];
		end
		load(id, rtr, 1'b0, dlc);
		slow <= sl;
		rival_en <= re;
		rival <= rv;
		TX_START <= 1'b1;
		@(posedge MCLK);
		TX_START <= 1'b0;
		// Slowest frame is 81 bits at four cycles each
		for (int i = 0; i < 600 && !done && !lost; i++) begin
			@(posedge MCLK);
			#1;
			done = TX_DONE === 1'b1;
			lost = ARB_LOST === 1'b1;
		end
		@(posedge MCLK);
		rival_en <= 1'b0;
		chk("lost arbitration", lose, lost);
		chk("frame finished", !lose, done);
		if (!lose) begin
			chk("bit count", n, ncap);
			chk("frame bits", e, cap & ({128{1'b1}} >> (128 - n)));
		end
	endtask : send

	// Every offset written, then read back; unmapped ones read zero
	task automatic t_regs;
		byte_t d;
		for (int a = 0; a < 16; a++) wr(4'(a), pat(a));
		for (int a = 0; a < 16; a++) begin
			rd(4'(a), d);
			chk("register", a > 12 ? 8'h00 : (a == 12 ? pat(a) & 8'h0F : pat(a)), d);
		end
		#1;
		chk("read data after", 8'h00, RDATA);
		@(posedge MCLK);
	endtask : t_regs

	task automatic t_tx;
		send(11'h5A3, 1'b0, 4'h2, 1'b0, 1'b0, 12'h000, 1'b0);
		send(11'h0F1, 1'b0, 4'h8, 1'b1, 1'b0, 12'h000, 1'b0);
		send(11'h40E, 1'b0, 4'hF, 1'b0, 1'b0, 12'h000, 1'b0);
		send(11'h2C5, 1'b1, 4'h3, 1'b0, 1'b0, 12'h000, 1'b0);
		send(11'h7FF, 1'b0, 4'h0, 1'b1, 1'b0, 12'h000, 1'b0);
	endtask : t_tx

	// Rival below, rival above, and a data frame beating a remote one
	task automatic t_arb;
		send(11'h5A3, 1'b0, 4'h1, 1'b0, 1'b1, {11'h5A2, 1'b0}, 1'b1);
		send(11'h5A3, 1'b0, 4'h1, 1'b0, 1'b1, {11'h5A4, 1'b0}, 1'b0);
		send(11'h2C5, 1'b1, 4'h1, 1'b0, 1'b1, {11'h2C5, 1'b0}, 1'b1);
	endtask : t_arb

	// Extended format cannot be sent from this buffer
	task automatic t_ext;
		load(11'h123, 1'b0, 1'b1, 4'h1);
		TX_START <= 1'b1;
		@(posedge MCLK);
		TX_START <= 1'b0;
		#1;
		chk("refused", 1'b1, TX_REFUSED);
		chk("busy", 1'b0, TX_BUSY);
		@(posedge MCLK);
	endtask : t_ext

	task automatic rx_frame(input logic rtr, input logic ide);
		RX_ID <= 11'h6B1;
		RX_RTR <= rtr;
		RX_IDE <= ide;
		RX_DLC <= 4'h2;
		RX_FRAME_WE <= 1'b1;
		@(posedge MCLK);
		RX_FRAME_WE <= 1'b0;
		repeat (2) @(posedge MCLK);
		#1;
		chk("remote flag", rtr, RTR_FLAG);
		chk("format flag", ide, FMT_EXT);
		@(posedge MCLK);
	endtask : rx_frame

	task automatic rx_byte(input int i);
		RX_BYTE_IDX <= 3'(i);
		RX_BYTE <= 8'hE0 | 8'(i);
		RX_BYTE_WE <= 1'b1;
		@(posedge MCLK);
		RX_BYTE_WE <= 1'b0;
		@(posedge MCLK);
	endtask : rx_byte

	// Remote frame captures no bytes; a two-byte frame drops the third
	task automatic t_rx;
		byte_t d;
		load(11'h000, 1'b0, 1'b0, 4'h0);
		rx_frame(1'b1, 1'b1);
		rd(4'h0, d);
		chk("id high", 8'hD6, d);
		rd(4'h1, d);
		chk("id low and flags", 8'h3D, d);
		rx_byte(0);
		rd(4'h4, d);
		chk("remote frame byte", pat(4), d);
		rx_frame(1'b0, 1'b0);
		for (int i = 0; i < 3; i++) rx_byte(i);
		for (int i = 0; i < 3; i++) begin
			rd(4'(4 + i), d);
			chk("received byte", i < 2 ? 8'hE0 | 8'(i) : pat(6), d);
		end
		rd(4'hC, d);
		chk("length", 8'h02, d);
	endtask : t_rx

	task automatic test_done;
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// Whole run is well under two thousand cycles; this bound is over ten times that
	initial begin
		repeat (20000) @(posedge MCLK);
		num_errors++;
		test_done;
	end

	initial begin
		ADDR = 4'h0;
		WDATA = 8'h00;
		WR = 1'b0;
		RD = 1'b0;
		TX_START = 1'b0;
		RX_FRAME_WE = 1'b0;
		RX_ID = 11'h000;
		RX_RTR = 1'b0;
		RX_IDE = 1'b0;
		RX_DLC = 4'h0;
		RX_BYTE_WE = 1'b0;
		RX_BYTE_IDX = 3'd0;
		RX_BYTE = 8'h00;
		slow = 1'b0;
		rival_en = 1'b0;
		rival = 12'h000;
		repeat (16) @(posedge MCLK);
		SYS_RST <= 1'b0;
		@(posedge MCLK);
		t_regs;
		t_tx;
		t_arb;
		t_ext;
		t_rx;
		test_done;
	end
endmodule : testbench

`default_nettype wire
